/* hdl/mdc_pkg.sv */
/*
  Shared constants of the eight-channel transfer engine: register map,
  field positions, reset values, write masks and engine states.
  Assumes a 9-bit word-aligned register address and 16-bit register data.
*/
package mdc_pkg;
  localparam int CH_NUM = 8;
  localparam int AW = 9;
  localparam int DW = 16;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_GLOBAL = 9'h000;
  localparam logic [AW-1:0] OFS_UPLIM = 9'h004;
  localparam logic [AW-1:0] OFS_LOLIM = 9'h008;
  localparam logic [AW-1:0] OFS_BUF = 9'h00c;
  localparam logic [AW-1:0] OFS_CH_BASE = 9'h020;
  localparam logic [AW-1:0] OFS_CH_STRIDE = 9'h020;
  localparam logic [4:0] OFS_CH_CTRL = 5'h00;
  localparam logic [4:0] OFS_CH_INT = 5'h04;
  localparam logic [4:0] OFS_CH_SRC = 5'h08;
  localparam logic [4:0] OFS_CH_DST = 5'h0c;
  localparam logic [4:0] OFS_CH_CNT = 5'h10;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int GC_ON_BIT = 15;
  localparam int GC_ARB_BIT = 0;
  localparam int CC_NULL_BIT = 10;
  localparam int CC_RELOAD_BIT = 9;
  localparam int CC_SWREQ_BIT = 8;
  localparam int CC_SAM_LSB = 6;
  localparam int CC_DAM_LSB = 4;
  localparam int CC_TRM_LSB = 2;
  localparam int CC_SIZE_BIT = 1;
  localparam int CC_ON_BIT = 0;
  localparam int CI_BUF_BIT = 15;
  localparam int CI_TSEL_LSB = 8;
  localparam int CI_HI_BIT = 7;
  localparam int CI_LO_BIT = 6;
  localparam int CI_DONE_BIT = 5;
  localparam int CI_HALF_BIT = 4;
  localparam int CI_OVR_BIT = 3;
  localparam int CI_HEN_BIT = 0;
  localparam logic [DW-1:0] GC_WMASK = 16'h8001;
  localparam logic [DW-1:0] CC_WMASK = 16'h07ff;
  localparam logic [DW-1:0] CI_WMASK = 16'h7ff9;
  localparam logic [DW-1:0] REG_RESET = 16'h0000;
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC = 2'h1;
  localparam logic [1:0] AM_DEC = 2'h2;
  localparam logic [6:0] TSEL_OFF = 7'h00;
  localparam logic [6:0] TSEL_CASCADE_LAST = 7'h50;
  localparam logic [DW-1:0] SFR_TOP = 16'h07ff;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_DUMMY = 2'b11
  } mdc_state_t;
endpackage : mdc_pkg

/* hdl/mdc_arb_if.sv */
/*
  Carrier between the engine core and its channel arbiter.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface mdc_arb_if #(parameter int N = 8);
  logic [N-1:0] req;
  logic rr;
  logic take;
  logic valid;
  logic [$clog2(N)-1:0] idx;
  modport core (output req, output rr, output take, input valid, input idx);
  modport arb (input req, input rr, input take, output valid, output idx);
endinterface : mdc_arb_if

/* hdl/mdc_arbiter.sv */
/*
  Channel arbiter: fixed priority or round robin over the requests.
  Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/10ps
module mdc_arbiter import mdc_pkg::*; #(parameter int N = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  mdc_arb_if.arb arb
);
  localparam int IW = $clog2(N);
  logic [IW-1:0] last;
  logic [N-1:0] elig;
  logic [IW-1:0] pick;
  logic found;
  logic [IW-1:0] cand;

  always_comb begin
    cand = '0;
    elig = arb.req;
    // the channel just served steps aside while anyone else waits
    if ((arb.req & ~(N'(1) << last)) != '0) begin
      elig = arb.req & ~(N'(1) << last);
    end
    pick = '0;
    found = 1'b0;
    for (int i = 0; i < N; i++) begin
      cand = arb.rr ? IW'(last + IW'(1) + IW'(i)) : IW'(i);
      if (!found && elig[cand]) begin
        pick = cand;
        found = 1'b1;
      end
    end
  end

  assign arb.valid = found;
  assign arb.idx = pick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last <= '1;
    end else if (ce_i && arb.take) begin
      last <= pick;
    end
  end
endmodule : mdc_arbiter

/* hdl/mdc_engine.sv */
/*
  Eight-channel memory-to-memory transfer engine with its register file.
  Assumes a register master on the same clock, a data-space port that
  answers each request with a one-cycle ack, and trigger pulses that
  come from logic on the same clock.
*/
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - engine_on clear aborts all channels
// - bit 0 picks round robin or fixed
// - dummy_write_mode adds source write per write
// - restore bit reloads pointers at next start
// - repeated modes always reload pointers
// - software_request starts transfer, hardware clears
// - source_address_mode fixed, increment, decrement
// - destination_address_mode fixed, increment, decrement
// - transfer_mode_select chooses four modes
// - size bit one byte, zero word
// - channel_on enables the channel
// - buffered_write_pending shows unwritten buffer
// - trigger_select picks source, zero none
// - upper_limit_flag on access above limit
// - lower_limit_flag below limit above SFRs
// - limits checked at the actual access
// - completion_flag reports session end
// - halfway_flag at half the count
// - retrigger_overrun_flag on trigger while busy
// - halfway enable adds halfway interrupt
// - software flag set raises no interrupt
// - cascade codes select channel completions
// - limit violation terminates and interrupts
// - fixed priority lowest wins, no retrigger
// - continuous runs to zero, one-shot single
// - address bit 0 selects byte lane
module mdc_engine import mdc_pkg::*; (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [AW-1:0] ADDR_I,
  input wire logic [DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DW-1:0] RDATA_O,
  input wire logic [127:0] TRIG_I,
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic [DW-1:0] MEM_ADDR_O,
  output logic [DW-1:0] MEM_WDATA_O,
  output logic [1:0] MEM_BE_O,
  input wire logic MEM_ACK_I,
  input wire logic [DW-1:0] MEM_RDATA_I,
  output logic [CH_NUM-1:0] CH_IRQ_O
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DW-1:0] gctrl, uplim, lolim, ebuf, acc_addr, next_cnt;
  logic [DW-1:0] cctrl [CH_NUM], src [CH_NUM], dst [CH_NUM], cnt [CH_NUM];
  logic [DW-1:0] sv_src [CH_NUM], sv_dst [CH_NUM], sv_cnt [CH_NUM];
  logic [6:0] tsel [CH_NUM];
  logic [4:0] flags [CH_NUM];
  logic [CH_NUM-1:0] hen, pend, reload_due, done_pulse, hw_irq, trig_hit, wr_ctrl, wr_int, go;
  logic buf_pend, engine_on, viol_hi, viol_lo, cur_byte, finish;
  mdc_state_t state;
  logic [2:0] cur;
  logic [1:0] cur_mode;
  logic [127:0] trig_vec;
  mdc_arb_if #(.N(CH_NUM)) arb_bus ();
  mdc_arbiter #(.N(CH_NUM)) u_arb (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .arb(arb_bus)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic ch_hit(input logic [AW-1:0] a, input logic [2:0] c,
                                  input logic [4:0] reg_ofs);
    ch_hit = (a == AW'(OFS_CH_BASE + AW'(c) * OFS_CH_STRIDE + AW'(reg_ofs)));
  endfunction : ch_hit

  function automatic logic [DW-1:0] step_addr(input logic [DW-1:0] a, input logic [1:0] m,
                                              input logic byte_sz);
    logic [DW-1:0] d;
    d = byte_sz ? 16'h0001 : 16'h0002;
    unique case (m)
      AM_INC: step_addr = a + d;
      AM_DEC: step_addr = a - d;
      default: step_addr = a; // reserved code holds the pointer like fixed
    endcase
  endfunction : step_addr

  assign engine_on = gctrl[GC_ON_BIT];
  assign cur_byte = cctrl[cur][CC_SIZE_BIT];
  assign cur_mode = cctrl[cur][CC_TRM_LSB +: 2];

  // ----------------------------------------------------------------
  // triggers and arbitration
  // ----------------------------------------------------------------
  always_comb begin
    trig_vec = TRIG_I;
    for (int k = 0; k < CH_NUM; k++) begin
      trig_vec[TSEL_CASCADE_LAST - 7'(k)] = done_pulse[k];
    end
  end

  generate
    for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
      assign wr_ctrl[c] = WR_I && ch_hit(ADDR_I, 3'(c), OFS_CH_CTRL);
      assign wr_int[c] = WR_I && ch_hit(ADDR_I, 3'(c), OFS_CH_INT);
      assign trig_hit[c] = (tsel[c] != TSEL_OFF) && trig_vec[tsel[c]];
      assign arb_bus.req[c] = engine_on && cctrl[c][CC_ON_BIT]
        && (pend[c] || cctrl[c][CC_SWREQ_BIT]);
    end
  endgenerate
  assign arb_bus.rr = gctrl[GC_ARB_BIT];
  assign arb_bus.take = (state == ST_IDLE) && arb_bus.valid && CE_I;
  always_comb begin
    go = '0;
    go[arb_bus.idx] = arb_bus.take;
  end
  // ----------------------------------------------------------------
  // data-space access
  // ----------------------------------------------------------------
  assign acc_addr = (state == ST_WRITE) ? dst[cur] : src[cur];
  // judged on the address actually presented, never ahead of time
  assign viol_hi = acc_addr > uplim;
  assign viol_lo = (acc_addr < lolim) && (acc_addr > SFR_TOP);
  assign MEM_REQ_O = (state != ST_IDLE) && !viol_hi && !viol_lo;
  assign MEM_WE_O = (state != ST_READ);
  assign MEM_ADDR_O = acc_addr;
  assign MEM_WDATA_O = ebuf;
  assign MEM_BE_O = !cur_byte ? 2'h3 : (acc_addr[0] ? 2'h2 : 2'h1);
  assign finish = MEM_ACK_I && MEM_REQ_O
    && ((state == ST_DUMMY) || (state == ST_WRITE && !cctrl[cur][CC_NULL_BIT]));
  assign next_cnt = cnt[cur] - 16'h0001;

  // ----------------------------------------------------------------
  // engine sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      cur <= 3'h0;
      ebuf <= REG_RESET;
      buf_pend <= 1'b0;
    end else if (CE_I) begin
      if (!engine_on || !cctrl[cur][CC_ON_BIT] && state != ST_IDLE) begin
        state <= ST_IDLE;
        buf_pend <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (arb_bus.take) begin
              cur <= arb_bus.idx;
              state <= ST_READ;
            end
          end
          ST_READ: begin
            if (viol_hi || viol_lo) begin
              state <= ST_IDLE;
            end else if (MEM_ACK_I) begin
              // a byte is copied to both lanes, the write enables pick one
              ebuf <= cur_byte ? {2{src[cur][0] ? MEM_RDATA_I[15:8] : MEM_RDATA_I[7:0]}}
                : MEM_RDATA_I;
              buf_pend <= 1'b1;
              state <= ST_WRITE;
            end
          end
          ST_WRITE: begin
            if (viol_hi || viol_lo) begin
              state <= ST_IDLE;
            end else if (MEM_ACK_I) begin
              buf_pend <= cctrl[cur][CC_NULL_BIT];
              state <= cctrl[cur][CC_NULL_BIT] ? ST_DUMMY : ST_IDLE;
            end
          end
          ST_DUMMY: begin
            if (viol_hi || viol_lo) begin
              state <= ST_IDLE;
            end else if (MEM_ACK_I) begin
              buf_pend <= 1'b0;
              state <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // module-level registers and register reads
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      gctrl <= REG_RESET;
      uplim <= REG_RESET;
      lolim <= REG_RESET;
      RDATA_O <= REG_RESET;
    end else if (CE_I) begin
      if (WR_I && ADDR_I == OFS_GLOBAL) gctrl <= WDATA_I & GC_WMASK;
      if (WR_I && ADDR_I == OFS_UPLIM) uplim <= WDATA_I;
      if (WR_I && ADDR_I == OFS_LOLIM) lolim <= WDATA_I;
      if (RD_I) begin
        RDATA_O <= REG_RESET; // unmapped addresses read zero
        if (ADDR_I == OFS_GLOBAL) RDATA_O <= gctrl;
        if (ADDR_I == OFS_UPLIM) RDATA_O <= uplim;
        if (ADDR_I == OFS_LOLIM) RDATA_O <= lolim;
        if (ADDR_I == OFS_BUF) RDATA_O <= ebuf;
        for (int c = 0; c < CH_NUM; c++) begin
          if (ch_hit(ADDR_I, 3'(c), OFS_CH_CTRL)) RDATA_O <= cctrl[c];
          if (ch_hit(ADDR_I, 3'(c), OFS_CH_INT)) begin
            RDATA_O <= {buf_pend && cur == 3'(c), tsel[c], flags[c], 2'h0, hen[c]};
          end
          if (ch_hit(ADDR_I, 3'(c), OFS_CH_SRC)) RDATA_O <= src[c];
          if (ch_hit(ADDR_I, 3'(c), OFS_CH_DST)) RDATA_O <= dst[c];
          if (ch_hit(ADDR_I, 3'(c), OFS_CH_CNT)) RDATA_O <= cnt[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel registers: software first, hardware events win
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int c = 0; c < CH_NUM; c++) begin
        cctrl[c] <= REG_RESET;
        tsel[c] <= TSEL_OFF;
        flags[c] <= 5'h00;
        src[c] <= REG_RESET;
        dst[c] <= REG_RESET;
        cnt[c] <= REG_RESET;
        sv_src[c] <= REG_RESET;
        sv_dst[c] <= REG_RESET;
        sv_cnt[c] <= REG_RESET;
      end
      hen <= '0;
      pend <= '0;
      reload_due <= '0;
      done_pulse <= '0;
      hw_irq <= '0;
    end else if (CE_I) begin
      done_pulse <= '0;
      hw_irq <= '0;
      for (int c = 0; c < CH_NUM; c++) begin
        if (wr_ctrl[c]) begin
          cctrl[c] <= WDATA_I & CC_WMASK;
          if (WDATA_I[CC_ON_BIT] && !cctrl[c][CC_ON_BIT]) begin
            flags[c][CI_DONE_BIT-3] <= 1'b0;
          end
        end
        if (wr_int[c]) begin
          tsel[c] <= WDATA_I[CI_TSEL_LSB +: 7];
          flags[c] <= WDATA_I[CI_OVR_BIT +: 5];
          hen[c] <= WDATA_I[CI_HEN_BIT];
        end
        if (WR_I && ch_hit(ADDR_I, 3'(c), OFS_CH_SRC)) begin
          src[c] <= WDATA_I;
          sv_src[c] <= WDATA_I;
        end
        if (WR_I && ch_hit(ADDR_I, 3'(c), OFS_CH_DST)) begin
          dst[c] <= WDATA_I;
          sv_dst[c] <= WDATA_I;
        end
        if (WR_I && ch_hit(ADDR_I, 3'(c), OFS_CH_CNT)) begin
          cnt[c] <= WDATA_I;
          sv_cnt[c] <= WDATA_I;
        end
        if (trig_hit[c] && cctrl[c][CC_ON_BIT]) begin
          pend[c] <= 1'b1;
          if (pend[c] || (state != ST_IDLE && cur == 3'(c))) begin
            flags[c][CI_OVR_BIT-3] <= 1'b1;
          end
        end
        if (go[c] && reload_due[c]) begin
          src[c] <= sv_src[c];
          dst[c] <= sv_dst[c];
          cnt[c] <= sv_cnt[c];
          reload_due[c] <= 1'b0;
        end
        if (!engine_on) begin
          pend[c] <= 1'b0;
        end
      end
      if (state != ST_IDLE && (viol_hi || viol_lo)) begin
        flags[cur][CI_HI_BIT-3] <= flags[cur][CI_HI_BIT-3] | viol_hi;
        flags[cur][CI_LO_BIT-3] <= flags[cur][CI_LO_BIT-3] | viol_lo;
        pend[cur] <= 1'b0;
        cctrl[cur][CC_SWREQ_BIT] <= 1'b0;
        hw_irq[cur] <= 1'b1;
      end
      if (finish) begin
        src[cur] <= step_addr(src[cur], cctrl[cur][CC_SAM_LSB +: 2], cur_byte);
        dst[cur] <= step_addr(dst[cur], cctrl[cur][CC_DAM_LSB +: 2], cur_byte);
        cnt[cur] <= next_cnt;
        if (!cur_mode[1]) begin
          pend[cur] <= 1'b0;
        end
        if (next_cnt == (sv_cnt[cur] >> 1)) begin
          flags[cur][CI_HALF_BIT-3] <= 1'b1;
          hw_irq[cur] <= hen[cur];
        end
        if (next_cnt == REG_RESET) begin
          flags[cur][CI_DONE_BIT-3] <= 1'b1;
          hw_irq[cur] <= 1'b1;
          done_pulse[cur] <= 1'b1;
          pend[cur] <= 1'b0;
          cctrl[cur][CC_SWREQ_BIT] <= 1'b0;
          reload_due[cur] <= cur_mode[0] || cctrl[cur][CC_RELOAD_BIT];
          if (!cur_mode[0]) begin
            cctrl[cur][CC_ON_BIT] <= 1'b0;
          end
        end
      end
    end
  end

  assign CH_IRQ_O = hw_irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  AST_ENGINE_OFF_ABORT: assert property (CE_I && !engine_on |=> state == ST_IDLE)
    else $error("engine still busy after disable");
  AST_NULL_DUMMY: assert property (CE_I && state == ST_WRITE && MEM_ACK_I && MEM_REQ_O
    && cctrl[cur][CC_NULL_BIT] && engine_on && cctrl[cur][CC_ON_BIT]
    |=> state == ST_DUMMY && MEM_ADDR_O == src[cur])
    else $error("dummy write missing");
  AST_SWREQ_CLEAR: assert property (CE_I && finish && next_cnt == 16'h0000
    && !wr_ctrl[cur] |=> !cctrl[$past(cur)][CC_SWREQ_BIT])
    else $error("software request not cleared");
  AST_INC_STEP: assert property (CE_I && finish && cctrl[cur][CC_SAM_LSB +: 2] == AM_INC
    && !cur_byte |=> src[$past(cur)] == $past(src[cur]) + 16'h0002)
    else $error("source step wrong");
  AST_NO_BAD_ACCESS: assert property (CE_I && state != ST_IDLE && viol_lo && engine_on
    && cctrl[cur][CC_ON_BIT] |=> state == ST_IDLE && flags[$past(cur)][CI_LO_BIT-3])
    else $error("lower limit violation not terminated");
  AST_LIMIT_IRQ: assert property (CE_I && state != ST_IDLE && viol_hi && engine_on
    && cctrl[cur][CC_ON_BIT] |=> CH_IRQ_O[$past(cur)] && flags[$past(cur)][CI_HI_BIT-3])
    else $error("limit violation not flagged");
  AST_DONE_FLAG: assert property (CE_I && finish && next_cnt == 16'h0000
    && !wr_int[cur] |=> flags[$past(cur)][CI_DONE_BIT-3] && CH_IRQ_O[$past(cur)])
    else $error("completion not reported");
  AST_BUF_PEND: assert property (CE_I && state == ST_READ && MEM_ACK_I && MEM_REQ_O
    && engine_on && cctrl[cur][CC_ON_BIT] |=> buf_pend [*1] ##0 state == ST_WRITE)
    else $error("buffer pending flag not set");
  AST_BYTE_LANE: assert property (MEM_REQ_O && cur_byte
    |-> MEM_BE_O == (MEM_ADDR_O[0] ? 2'h2 : 2'h1))
    else $error("byte lane wrong");

  COV_NULL_WRITE: cover property (state == ST_DUMMY && MEM_ACK_I);
  COV_CASCADE: cover property (done_pulse != '0 ##1 arb_bus.take);
  COV_LIMIT: cover property (state != ST_IDLE && viol_lo);
  COV_OVERRUN: cover property (flags[0][CI_OVR_BIT-3]);
endmodule : mdc_engine

/* sim/mdc_mem_model.sv */
/*
  Data-space partner of the transfer engine: a memory that answers each
  request after a chosen number of wait cycles.
  Assumes the engine's clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
module mdc_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [3:0] wait_cnt;
  // read data is a fixed function of the address; between acks the data
  // lines toggle, so a sample taken an odd number of cycles after the ack cycle reads inverted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_o <= 16'h0000;
    end else if (req_i && !ack_o && wait_cnt >= delay_i) begin
      ack_o <= 1'b1;
      wait_cnt <= 4'h0;
      rdata_o <= addr_i ^ 16'ha5c3;
    end else begin
      ack_o <= 1'b0;
      wait_cnt <= (req_i && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : mdc_mem_model

/* sim/mdc_engine_bench.sv */
/*
  Self-checking bench of mdc_engine: registers, transfers, limits,
  triggers and abort.
  Assumes mdc_pkg and the data-space partner mdc_mem_model.
*/
`timescale 1ns/10ps
module mdc_engine_bench import mdc_pkg::*; ;
  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] mask;
    logic [33:0] val;
  } mdc_note_t;
  mdc_note_t notes[$];
  int n_mismatch = 0;
  int comparisons = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic ce = 1'b1;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [127:0] trig = '0;
  logic [3:0] delay = 4'h0;
  logic [DW-1:0] rdata, mem_addr, mem_wdata, mem_rdata, src, b;
  logic mem_req, mem_we, mem_ack;
  logic [1:0] mem_be;
  logic [CH_NUM-1:0] irq;
  logic [6:0] code;
  int k;

  mdc_engine i_mdc_engine (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TRIG_I(trig),
    .MEM_REQ_O(mem_req), .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr),
    .MEM_WDATA_O(mem_wdata), .MEM_BE_O(mem_be), .MEM_ACK_I(mem_ack),
    .MEM_RDATA_I(mem_rdata), .CH_IRQ_O(irq));
  mdc_mem_model i_mdc_mem_model (.clk_i(clk), .rst_i(rst), .req_i(mem_req),
    .addr_i(mem_addr), .delay_i(delay), .ack_o(mem_ack), .rdata_o(mem_rdata));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic tally(input logic [33:0] act, input logic [33:0] exp);
    comparisons++;
    if (act !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : tally
  task automatic cmp_rd(input logic [15:0] act, input logic [15:0] m, input logic [15:0] exp);
    tally({18'h0, act & m}, {18'h0, exp});
  endtask : cmp_rd
  task automatic cmp_wr(input logic [33:0] act, input logic [33:0] exp);
    tally(act, exp);
  endtask : cmp_wr
  task automatic cmp_irq(input logic [7:0] act, input logic [7:0] exp);
    tally({26'h0, act}, {26'h0, exp});
  endtask : cmp_irq
  // a result with no note waiting meets kind 3 and counts as a mismatch
  task automatic take(input logic [1:0] kind, input logic [33:0] act);
    mdc_note_t n;
    n = '{kind: 2'd3, mask: 16'h0000, val: 34'h0};
    if (notes.size() > 0) n = notes.pop_front();
    if (n.kind !== kind) tally({32'h0, kind}, {32'h0, n.kind});
    else if (kind == 2'd0) cmp_rd(act[15:0], n.mask, n.val[15:0]);
    else if (kind == 2'd1) cmp_wr(act, n.val);
    else cmp_irq(act[7:0], n.val[7:0]);
  endtask : take
  always @(negedge clk) begin
    if (rd_seen === 1'b1) take(2'd0, {18'h0, rdata});
    if ({mem_req, mem_we, mem_ack} === 3'b111) take(2'd1, {mem_be, mem_addr, mem_wdata});
    if (irq !== 8'h00) take(2'd2, {26'h0, irq});
    rd_seen = rd;
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  function automatic logic [8:0] cha(input int n, input logic [4:0] ofs);
    return OFS_CH_BASE + OFS_CH_STRIDE * n[8:0] + {4'h0, ofs};
  endfunction : cha
  task automatic note(input logic [1:0] kind, input logic [33:0] v);
    notes.push_back('{kind: kind, mask: 16'hffff, val: v});
  endtask : note
  task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [8:0] a, input logic [15:0] m, input logic [15:0] e);
    notes.push_back('{kind: 2'd0, mask: m, val: {18'h0, e}});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic setch(input int n, input logic [15:0] s, input logic [15:0] d,
                       input logic [15:0] c, input logic [15:0] iv, input logic [15:0] ct);
    wr_reg(cha(n, OFS_CH_SRC), s);
    wr_reg(cha(n, OFS_CH_DST), d);
    wr_reg(cha(n, OFS_CH_CNT), c);
    wr_reg(cha(n, OFS_CH_INT), iv);
    wr_reg(cha(n, OFS_CH_CTRL), ct);
  endtask : setch
  task automatic pulse(input logic [6:0] c);
    @(posedge clk);
    trig[c] <= 1'b1;
    @(posedge clk);
    trig <= '0;
  endtask : pulse
  task automatic settle;
    for (int i = 0; i < 400 && notes.size() > 0; i++) @(posedge clk);
    if (notes.size() > 0) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, notes.size(), 0);
      complete_run();
    end
    repeat (4) @(posedge clk);
  endtask : settle

  initial begin
    void'($urandom(13365));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_GLOBAL, 16'hffff, REG_RESET);
    rd_reg(cha(0, OFS_CH_INT), 16'hffff, REG_RESET);
    rd_reg(9'h1fc, 16'hffff, 16'h0000);
    wr_reg(OFS_GLOBAL, 16'hffff);
    rd_reg(OFS_GLOBAL, 16'hffff, 16'h8001);
    wr_reg(cha(0, OFS_CH_CTRL), 16'hfffe);
    rd_reg(cha(0, OFS_CH_CTRL), 16'hffff, 16'h07fe);
    wr_reg(cha(0, OFS_CH_CTRL), 16'h0000);
    // flags set by software must stay silent: any pulse finds no note
    wr_reg(cha(0, OFS_CH_INT), 16'hffff);
    rd_reg(cha(0, OFS_CH_INT), 16'hffff, 16'h7ff9);
    wr_reg(cha(0, OFS_CH_INT), 16'h0000);
    wr_reg(OFS_UPLIM, 16'hffff);
    wr_reg(OFS_GLOBAL, 16'h8000);
    settle();
    src = 16'h0800 | (16'($urandom) & 16'h07fe);
    delay <= 4'($urandom_range(3));
    setch(4, 16'h0c00, 16'h0e00, 16'h0001, {1'b0, TSEL_CASCADE_LAST, 8'h00}, 16'h0001);
    note(2'd1, {2'b11, 16'h1000, src ^ 16'ha5c3});
    note(2'd2, 34'h1);
    note(2'd1, {2'b11, 16'h1002, (src + 16'h0002) ^ 16'ha5c3});
    note(2'd2, 34'h1);
    note(2'd1, {2'b11, 16'h0e00, 16'h0c00 ^ 16'ha5c3});
    note(2'd2, 34'h10);
    setch(0, src, 16'h1000, 16'h0002, 16'h0001, 16'h0159);
    settle();
    rd_reg(cha(0, OFS_CH_INT), 16'h0030, 16'h0030);
    rd_reg(cha(0, OFS_CH_CTRL), 16'h07ff, 16'h0058);
    rd_reg(cha(0, OFS_CH_SRC), 16'hffff, src + 16'h0004);
    b = 16'h0901 ^ 16'ha5c3;
    note(2'd1, {2'b01, 16'h0a00, b[15:8], b[15:8]});
    note(2'd1, {2'b10, 16'h0901, b[15:8], b[15:8]});
    note(2'd2, 34'h2);
    setch(1, 16'h0901, 16'h0a00, 16'h0001, 16'h0000, 16'h0583);
    settle();
    rd_reg(cha(1, OFS_CH_SRC), 16'hffff, 16'h0900);
    rd_reg(cha(1, OFS_CH_DST), 16'hffff, 16'h0a00);
    rd_reg(cha(1, OFS_CH_INT), 16'h8020, 16'h0020);
    code = 7'($urandom_range(72, 1));
    delay <= 4'h8;
    note(2'd1, {2'b11, 16'h0c00, 16'h0800 ^ 16'ha5c3});
    setch(3, 16'h0800, 16'h0c00, 16'h0004, {1'b0, code, 8'h00}, 16'h0005);
    pulse(code);
    repeat (2) @(posedge clk);
    pulse(code);
    settle();
    rd_reg(cha(3, OFS_CH_INT), 16'h0008, 16'h0008);
    rd_reg(cha(3, OFS_CH_CNT), 16'hffff, 16'h0003);
    wr_reg(cha(3, OFS_CH_INT), 16'h0000);
    pulse(7'h00);
    pulse(code);
    wr_reg(cha(3, OFS_CH_CTRL), 16'h0000);
    for (k = 0; k < 2; k++) begin
      wr_reg(OFS_LOLIM, k ? 16'h0000 : 16'h1000);
      wr_reg(OFS_UPLIM, k ? 16'h2000 : 16'hffff);
      note(2'd2, 34'h4);
      setch(2, k ? 16'h3000 : 16'h0900, 16'h0a00, 16'h0001, 16'h0000, 16'h0101);
      settle();
      rd_reg(cha(2, OFS_CH_INT), 16'h00c0, k ? 16'h0080 : 16'h0040);
      wr_reg(cha(2, OFS_CH_CTRL), 16'h0000);
    end
    wr_reg(OFS_UPLIM, 16'hffff);
    // a write while the clock enable is low must leave the register alone
    ce <= 1'b0;
    wr_reg(OFS_UPLIM, 16'h1234);
    ce <= 1'b1;
    rd_reg(OFS_UPLIM, 16'hffff, 16'hffff);
    // slow memory keeps the read phase open while the engine is switched off
    delay <= 4'hf;
    setch(5, 16'h0800, 16'h0c00, 16'h0008, 16'h0000, 16'h0109);
    for (k = 0; k < 100 && mem_req !== 1'b1; k++) @(negedge clk);
    tally({33'h0, mem_req}, 34'h1);
    if (mem_req !== 1'b1) complete_run();
    wr_reg(OFS_GLOBAL, 16'h0000);
    repeat (40) @(posedge clk);
    tally({33'h0, mem_req}, 34'h0);
    rd_reg(cha(5, OFS_CH_INT), 16'h0020, 16'h0000);
    settle();
    complete_run();
  end
endmodule : mdc_engine_bench
